// [ectp_pkg.sv]
// Shared constants and types for the Ethernet client traffic platform.
package ectp_pkg;
    localparam int unsigned ECTP_RXF_BYTES = 16384;
    localparam int unsigned ECTP_ADDR_BYTES = 6;
    localparam logic [47:0] ECTP_GEN_DA = 48'h1122_3344_5566;
    localparam logic [47:0] ECTP_GEN_SA_DEF = 48'h0200_0000_0001;
    localparam logic [15:0] ECTP_TYPE_VAL = 16'h0800;
    localparam logic [15:0] ECTP_VLAN_TPID = 16'h8100;
    localparam logic [15:0] ECTP_VLAN_TCI_DEF = 16'h0001;
    localparam logic [15:0] ECTP_SWEEP_MIN = 16'h0013;
    localparam logic [15:0] ECTP_HDR_BYTES = 16'h000E;
    localparam logic [15:0] ECTP_VLAN_BYTES = 16'h0004;
    localparam logic [15:0] ECTP_CORRUPT_DELTA = 16'h0001;
    localparam logic [15:0] ECTP_PAUSE_RST = 16'h0000;
    localparam logic [4:0] ECTP_REG_PCS_CONTROL = 5'h00;
    localparam logic [4:0] ECTP_REG_PCS_STATUS = 5'h01;
    localparam logic [4:0] ECTP_REG_ADV = 5'h04;
    localparam logic [4:0] ECTP_REG_GADV = 5'h09;
    localparam logic [4:0] ECTP_REG_SPD_DEF = 5'h11;
    localparam int unsigned ECTP_CTRL_LOOP_BIT = 14;
    localparam int unsigned ECTP_CTRL_ANEN_BIT = 12;
    localparam int unsigned ECTP_CTRL_ANRST_BIT = 9;
    localparam int unsigned ECTP_STAT_ANDONE_BIT = 5;
    localparam int unsigned ECTP_SPD_LO_BIT = 14;
    localparam int unsigned ECTP_DPX_BIT = 13;
    localparam logic [15:0] ECTP_ADV_SEL = 16'h0001;
    localparam logic [15:0] ECTP_ADV_ALL = 16'h01E1;
    localparam logic [15:0] ECTP_GADV_ALL = 16'h0300;
    localparam int unsigned ECTP_ADV_10H_BIT = 5;
    localparam int unsigned ECTP_GADV_HALF_BIT = 8;

    typedef enum logic [1:0] {
        ECTP_SRC_GEN = 2'b00,
        ECTP_SRC_EDIT = 2'b01,
        ECTP_SRC_LOOP = 2'b10,
        ECTP_SRC_LOOP_SWAP = 2'b11
    } ectp_src_e;

    typedef enum logic [1:0] {
        ECTP_SPD_1G = 2'b00,
        ECTP_SPD_100M = 2'b01,
        ECTP_SPD_10M = 2'b10
    } ectp_spd_e;

    typedef enum logic [2:0] {
        ECTP_ST_IDLE = 3'b000,
        ECTP_ST_ADV = 3'b001,
        ECTP_ST_GADV = 3'b010,
        ECTP_ST_CTRL = 3'b011,
        ECTP_ST_POLL = 3'b100,
        ECTP_ST_SPD = 3'b101,
        ECTP_ST_LOOPW = 3'b110
    } ectp_st_e;
endpackage : ectp_pkg

// [ectp_top.sv]
// Client traffic logic: generator, source select, receive frame FIFO and link setup.
//
// Function
// - Swap-loopback exchanges bytes 0-5 and 6-11.
// - Loopback sends received frames via the FIFO.
// - Type option sets length/type to 0800 hex.
// - Length option sets length/type to payload size.
// - VLAN adds a tag and shrinks the length field.
// - Corrupt option writes a wrong length.
// - Sweep goes from 19 bytes up, wrapping at frame size.
// - Short frames leave unpadded; the MAC pads them.
// - Pause length is 16 bits; send-pause raises the request.
// - Single command sends exactly one frame.
// - Continuous command sends frames until stop.
// - Single, continuous, stop and pause commands act only with the generator as source.
// - Generated frames carry destination 11-22-33-44-55-66.
// - Receive FIFO holds 16 KB, drops frames when full.
// - No processor FIFO reads during loopback.
// - Frame counter needs a good address; byte counter counts all.
// - Physical loopback or no PHY forces gigabit full duplex.
// - Restart advertises all or one mode, restarts negotiation.
// - Negotiated speed and duplex are read and applied.
// - Physical loopback sets bit 14 of register 0.
// - Bit 5 of register 1 marks negotiation done.
// - Loopback wires GMII transmit to receive, or asks over MDIO.
// - A frame without room is dropped whole.
// - Flush discards stored frames.
module ectp_top
    import ectp_pkg::*;
#(
    parameter int unsigned RXF_BYTES = ECTP_RXF_BYTES,
    parameter logic [47:0] GEN_SA = ECTP_GEN_SA_DEF,
    parameter logic [15:0] VLAN_TCI = ECTP_VLAN_TCI_DEF,
    parameter logic [4:0] SPD_REG = ECTP_REG_SPD_DEF,
    parameter bit LOOP_VIA_MDIO = 1'b1
)
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Platform configuration.
    input wire logic [1:0] tx_source,
    input wire logic opt_type,
    input wire logic opt_length,
    input wire logic opt_vlan,
    input wire logic opt_corrupt,
    input wire logic opt_sweep,
    input wire logic [15:0] frame_size,
    input wire logic [15:0] pause_len_cfg,
    input wire logic phy_loop_cfg,
    input wire logic phy_absent,
    input wire logic autoneg_auto,
    input wire logic [1:0] req_speed,
    input wire logic req_half,
    // Command pulses.
    input wire logic cmd_single,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic cmd_pause,
    input wire logic cmd_flush,
    input wire logic cmd_restart_an,
    // MAC receive client.
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic rx_err,
    input wire logic rx_addr_ok,
    // MAC transmit client.
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    output logic pause_req,
    output logic [15:0] pause_val,
    // Frame editor stream.
    input wire logic [7:0] ed_data,
    input wire logic ed_valid,
    input wire logic ed_last,
    output logic ed_ready,
    // Processor read of the receive FIFO.
    input wire logic cpu_rd,
    output logic [7:0] cpu_rd_data,
    output logic cpu_rd_valid,
    output logic cpu_rd_last,
    output logic cpu_frame_avail,
    // Statistics.
    output logic [31:0] stat_frames,
    output logic [31:0] stat_bytes,
    // Management access and MAC setup.
    output logic mgmt_req,
    output logic mgmt_wr,
    output logic [4:0] mgmt_reg,
    output logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_done,
    output logic [1:0] mac_speed,
    output logic mac_half,
    output logic cfg_busy,
    output logic gmii_loop
);
    localparam int unsigned AW = $clog2(RXF_BYTES);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] wt;
        logic [AW:0] rb;
        logic [AW:0] ri;
        logic drop;
        logic rx_busy;
        logic [7:0] tx_data;
        logic tx_valid;
        logic tx_last;
        logic ed_ready;
        logic [7:0] cpu_data;
        logic cpu_valid;
        logic cpu_last;
        logic cpu_avail;
        logic gen_run;
        logic gen_one;
        logic gen_busy;
        logic [15:0] gen_idx;
        logic [15:0] gen_len;
        logic pause_req;
        logic [15:0] pause_val;
        logic [31:0] stat_frames;
        logic [31:0] stat_bytes;
        ectp_st_e st;
        logic mg_req;
        logic mg_wr;
        logic [4:0] mg_reg;
        logic [15:0] mg_wdata;
        logic mg_wait;
        logic loop_seen;
        logic [1:0] mac_speed;
        logic mac_half;
        logic cfg_busy;
        logic gmii_loop;
    } ectp_state_s;

    ectp_state_s s_r;
    ectp_state_s s_nxt;
    logic [8:0] mem [RXF_BYTES];
    logic mem_we;
    logic [AW-1:0] mem_wa;
    logic [8:0] mem_wd;

    function automatic logic [7:0] ectp_gen_byte(input logic [15:0] idx, input logic [15:0] len);
        logic [15:0] pay;
        logic [15:0] lt;
        logic [15:0] o;
        logic [31:0] tag;
        logic [7:0] b;
        pay = len - ECTP_HDR_BYTES - (opt_vlan ? ECTP_VLAN_BYTES : 16'h0000);
        lt = opt_length ? pay : 16'h0000;
        if (opt_type)
            lt = ECTP_TYPE_VAL;
        if (opt_corrupt)
            lt = pay + ECTP_CORRUPT_DELTA;
        tag = {ECTP_VLAN_TPID, VLAN_TCI};
        o = idx - 16'(2 * ECTP_ADDR_BYTES);
        if (idx < 16'(ECTP_ADDR_BYTES))
            b = ECTP_GEN_DA[8 * (5 - int'(idx[2:0])) +: 8];
        else if (idx < 16'(2 * ECTP_ADDR_BYTES))
            b = GEN_SA[8 * (11 - int'(idx[3:0])) +: 8];
        else if (opt_vlan && o < ECTP_VLAN_BYTES)
            b = tag[8 * (3 - int'(o[1:0])) +: 8];
        else
        begin
            o = o - (opt_vlan ? ECTP_VLAN_BYTES : 16'h0000);
            b = (o == 16'h0000) ? lt[15:8] : ((o == 16'h0001) ? lt[7:0] : o[7:0]);
        end
        return b;
    endfunction : ectp_gen_byte

    function automatic logic [AW:0] ectp_map(input logic [AW:0] i, input logic swap);
        logic [AW:0] m;
        m = i;
        if (swap && i < (AW + 1)'(ECTP_ADDR_BYTES))
            m = i + (AW + 1)'(ECTP_ADDR_BYTES);
        else if (swap && i < (AW + 1)'(2 * ECTP_ADDR_BYTES))
            m = i - (AW + 1)'(ECTP_ADDR_BYTES);
        return m;
    endfunction : ectp_map

    always_comb
    begin
        logic src_gen;
        logic src_loop;
        logic can_load;
        logic accept;
        logic consume;
        logic [AW:0] used;
        logic [AW:0] ra;
        logic [7:0] rd_byte;
        logic rd_last;
        src_gen = tx_source == ECTP_SRC_GEN;
        src_loop = tx_source[1];
        can_load = !s_r.tx_valid || tx_ready;
        used = s_r.wt - s_r.rb;
        ra = s_r.rb + ectp_map(s_r.ri, tx_source == ECTP_SRC_LOOP_SWAP);
        rd_byte = mem[ra[AW-1:0]][7:0];
        ra = s_r.rb + s_r.ri;
        rd_last = mem[ra[AW-1:0]][8];
        s_nxt = s_r;
        s_nxt.cpu_valid = 1'b0;
        s_nxt.pause_req = 1'b0;
        s_nxt.mg_req = 1'b0;
        s_nxt.ed_ready = 1'b0;
        mem_we = 1'b0;
        mem_wa = s_r.wt[AW-1:0];
        mem_wd = {rx_last, rx_data};
        if (can_load)
            s_nxt.tx_valid = 1'b0;

        accept = !s_r.drop && !used[AW];
        if (rx_valid)
        begin
            s_nxt.stat_bytes = s_r.stat_bytes + 32'h0000_0001;
            s_nxt.rx_busy = !rx_last;
            mem_we = accept;
            if (accept)
                s_nxt.wt = s_r.wt + 1'b1;
            else
                s_nxt.drop = 1'b1;
            if (rx_last)
            begin
                s_nxt.drop = 1'b0;
                if (!rx_err && rx_addr_ok)
                    s_nxt.stat_frames = s_r.stat_frames + 32'h0000_0001;
                if (accept && !rx_err)
                    s_nxt.wp = s_nxt.wt;
                else
                    s_nxt.wt = s_r.wp;
            end
        end

        consume = 1'b0;
        if (s_r.rb != s_r.wp)
        begin
            if (src_loop && can_load)
            begin
                consume = 1'b1;
                s_nxt.tx_valid = 1'b1;
                s_nxt.tx_data = rd_byte;
                s_nxt.tx_last = rd_last;
            end
            else if (!src_loop && cpu_rd)
            begin
                consume = 1'b1;
                s_nxt.cpu_valid = 1'b1;
                s_nxt.cpu_data = rd_byte;
                s_nxt.cpu_last = rd_last;
            end
        end
        if (consume)
        begin
            s_nxt.ri = rd_last ? '0 : s_r.ri + 1'b1;
            if (rd_last)
                s_nxt.rb = s_r.rb + s_r.ri + 1'b1;
        end
        if (cmd_flush)
        begin
            s_nxt.wp = '0;
            s_nxt.wt = '0;
            s_nxt.rb = '0;
            s_nxt.ri = '0;
            s_nxt.drop = rx_valid ? !rx_last : s_r.rx_busy;
        end
        used = s_nxt.rb ^ s_nxt.wp;
        s_nxt.cpu_avail = |used;

        if (tx_source == ECTP_SRC_EDIT)
        begin
            if (ed_valid && s_r.ed_ready)
            begin
                s_nxt.tx_valid = 1'b1;
                s_nxt.tx_data = ed_data;
                s_nxt.tx_last = ed_last;
            end
            else
                s_nxt.ed_ready = !s_nxt.tx_valid;
        end

        if (src_gen)
        begin
            if (cmd_single)
                s_nxt.gen_one = 1'b1;
            if (cmd_start)
                s_nxt.gen_run = 1'b1;
            if (cmd_stop)
                s_nxt.gen_run = 1'b0;
            if (cmd_pause)
                s_nxt.pause_req = 1'b1;
            if (!s_r.gen_busy && (s_r.gen_run || s_r.gen_one))
            begin
                s_nxt.gen_busy = 1'b1;
                s_nxt.gen_one = 1'b0;
                s_nxt.gen_idx = '0;
                if (!opt_sweep)
                    s_nxt.gen_len = frame_size;
                else if (s_r.gen_len < ECTP_SWEEP_MIN || s_r.gen_len >= frame_size)
                    s_nxt.gen_len = ECTP_SWEEP_MIN;
                else
                    s_nxt.gen_len = s_r.gen_len + 16'h0001;
            end
            else if (s_r.gen_busy && can_load)
            begin
                s_nxt.tx_valid = 1'b1;
                s_nxt.tx_data = ectp_gen_byte(s_r.gen_idx, s_r.gen_len);
                s_nxt.tx_last = s_r.gen_idx + 16'h0001 >= s_r.gen_len;
                s_nxt.gen_idx = s_r.gen_idx + 16'h0001;
                s_nxt.gen_busy = !s_nxt.tx_last;
            end
        end
        else
        begin
            s_nxt.gen_busy = 1'b0;
            s_nxt.gen_one = 1'b0;
            s_nxt.gen_run = 1'b0;
        end
        if (!s_nxt.pause_req && !s_r.pause_req)
            s_nxt.pause_val = pause_len_cfg;

        s_nxt.gmii_loop = phy_loop_cfg && !LOOP_VIA_MDIO;
        if (s_r.st != ECTP_ST_IDLE && !s_r.mg_wait)
        begin
            s_nxt.mg_req = 1'b1;
            s_nxt.mg_wait = 1'b1;
            s_nxt.mg_wr = 1'b1;
            s_nxt.mg_reg = ECTP_REG_PCS_CONTROL;
            s_nxt.mg_wdata = 16'(phy_loop_cfg) << ECTP_CTRL_LOOP_BIT;
            unique case (s_r.st)
                ECTP_ST_ADV:
                begin
                    s_nxt.mg_reg = ECTP_REG_ADV;
                    s_nxt.mg_wdata = autoneg_auto ? ECTP_ADV_ALL : (ECTP_ADV_SEL | ((req_speed == ECTP_SPD_1G) ?
                        16'h0000 : 16'h0001 << (ECTP_ADV_10H_BIT + 32'(!req_half) + 32'(!req_speed[1]) * 2)));
                end
                ECTP_ST_GADV:
                begin
                    s_nxt.mg_reg = ECTP_REG_GADV;
                    s_nxt.mg_wdata = autoneg_auto ? ECTP_GADV_ALL : ((req_speed == ECTP_SPD_1G) ?
                        16'h0001 << (ECTP_GADV_HALF_BIT + 32'(!req_half)) : 16'h0000);
                end
                ECTP_ST_CTRL:
                    s_nxt.mg_wdata = s_nxt.mg_wdata | (16'h0001 << ECTP_CTRL_ANEN_BIT) |
                        (16'h0001 << ECTP_CTRL_ANRST_BIT);
                ECTP_ST_POLL:
                begin
                    s_nxt.mg_wr = 1'b0;
                    s_nxt.mg_reg = ECTP_REG_PCS_STATUS;
                end
                ECTP_ST_SPD:
                begin
                    s_nxt.mg_wr = 1'b0;
                    s_nxt.mg_reg = SPD_REG;
                end
                ECTP_ST_LOOPW:
                    s_nxt.loop_seen = phy_loop_cfg;
                default:
                    s_nxt.mg_wr = 1'b1;
            endcase
        end
        else if (s_r.mg_wait && mgmt_done)
        begin
            s_nxt.mg_wait = 1'b0;
            unique case (s_r.st)
                ECTP_ST_ADV:
                    s_nxt.st = ECTP_ST_GADV;
                ECTP_ST_GADV:
                    s_nxt.st = ECTP_ST_CTRL;
                ECTP_ST_CTRL:
                    s_nxt.st = ECTP_ST_POLL;
                ECTP_ST_POLL:
                    s_nxt.st = mgmt_rdata[ECTP_STAT_ANDONE_BIT] ? ECTP_ST_SPD : ECTP_ST_POLL;
                ECTP_ST_SPD:
                begin
                    s_nxt.st = ECTP_ST_IDLE;
                    s_nxt.cfg_busy = 1'b0;
                    s_nxt.mac_speed = (mgmt_rdata[ECTP_SPD_LO_BIT +: 2] == 2'b10) ? ECTP_SPD_1G :
                        ((mgmt_rdata[ECTP_SPD_LO_BIT +: 2] == 2'b01) ? ECTP_SPD_100M : ECTP_SPD_10M);
                    s_nxt.mac_half = !mgmt_rdata[ECTP_DPX_BIT];
                end
                default:
                    s_nxt.st = ECTP_ST_IDLE;
            endcase
        end
        else if (s_r.st == ECTP_ST_IDLE)
        begin
            if (cmd_restart_an && !phy_loop_cfg && !phy_absent)
            begin
                s_nxt.st = ECTP_ST_ADV;
                s_nxt.cfg_busy = 1'b1;
            end
            else if (LOOP_VIA_MDIO && s_r.loop_seen != phy_loop_cfg)
                s_nxt.st = ECTP_ST_LOOPW;
        end
        if (phy_loop_cfg || phy_absent)
        begin
            s_nxt.mac_speed = ECTP_SPD_1G;
            s_nxt.mac_half = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    always_ff @(posedge core_clk)
    begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

    assign tx_data = s_r.tx_data;
    assign tx_valid = s_r.tx_valid;
    assign tx_last = s_r.tx_last;
    assign ed_ready = s_r.ed_ready;
    assign pause_req = s_r.pause_req;
    assign pause_val = s_r.pause_val;
    assign cpu_rd_data = s_r.cpu_data;
    assign cpu_rd_valid = s_r.cpu_valid;
    assign cpu_rd_last = s_r.cpu_last;
    assign cpu_frame_avail = s_r.cpu_avail;
    assign stat_frames = s_r.stat_frames;
    assign stat_bytes = s_r.stat_bytes;
    assign mgmt_req = s_r.mg_req;
    assign mgmt_wr = s_r.mg_wr;
    assign mgmt_reg = s_r.mg_reg;
    assign mgmt_wdata = s_r.mg_wdata;
    assign mac_speed = s_r.mac_speed;
    assign mac_half = s_r.mac_half;
    assign cfg_busy = s_r.cfg_busy;
    assign gmii_loop = s_r.gmii_loop;
endmodule : ectp_top

// [ectp_top_assertions.sv]
// Concurrent checks on the ports of the client traffic platform.
module ectp_top_assertions
    import ectp_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Generator and transmit side.
    input wire logic [1:0] tx_source,
    input wire logic cmd_pause,
    input wire logic pause_req,
    input wire logic [15:0] pause_val,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic tx_ready,
    // Receive side and statistics.
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic rx_err,
    input wire logic rx_addr_ok,
    input wire logic cpu_rd,
    input wire logic cpu_rd_valid,
    input wire logic [31:0] stat_frames,
    // Link setup.
    input wire logic phy_loop_cfg,
    input wire logic phy_absent,
    input wire logic cmd_restart_an,
    input wire logic cfg_busy,
    input wire logic [1:0] mac_speed,
    input wire logic mac_half
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_pause_pulse;
        pause_req ##1 !pause_req;
    endsequence
    sequence s_held_byte;
        tx_valid && $stable(tx_data) && $stable(tx_last);
    endsequence
    chk_pause_pulse: assert property (cmd_pause && tx_source == ECTP_SRC_GEN |=> s_pause_pulse)
        else $error("pause width");
    chk_pause_gate: assert property (cmd_pause && tx_source != ECTP_SRC_GEN |=> !pause_req)
        else $error("pause gate");
    chk_pause_value: assert property (pause_req |=> $stable(pause_val))
        else $error("pause length moved");
    chk_tx_hold: assert property (tx_valid && !tx_ready |=> s_held_byte)
        else $error("stalled byte lost");
    chk_gen_dest: assert property ($rose(tx_valid) && tx_source == ECTP_SRC_GEN |-> tx_data == ECTP_GEN_DA[47:40])
        else $error("bad first byte");
    chk_cpu_block: assert property (cpu_rd && tx_source[1] |=> !cpu_rd_valid)
        else $error("read in loopback");
    chk_stat_frame: assert property (rx_valid && rx_last && !rx_err && rx_addr_ok
        |=> stat_frames == $past(stat_frames) + 32'h0000_0001)
        else $error("frame count");
    chk_loop_speed: assert property (phy_loop_cfg || phy_absent |=> mac_speed == 2'b00 && !mac_half)
        else $error("loop speed");
    chk_restart_busy: assert property (cmd_restart_an && !phy_loop_cfg && !phy_absent |=> cfg_busy)
        else $error("restart idle");
endmodule : ectp_top_assertions

bind ectp_top ectp_top_assertions u_chk (.core_clk, .rst_n, .tx_source, .cmd_pause, .pause_req, .pause_val,
    .tx_data, .tx_valid, .tx_last, .tx_ready, .rx_valid, .rx_last, .rx_err, .rx_addr_ok, .cpu_rd, .cpu_rd_valid,
    .stat_frames, .phy_loop_cfg, .phy_absent, .cmd_restart_an, .cfg_busy, .mac_speed, .mac_half);

// [ectp_mac_model.sv]
// Behavioural MAC transmit sink and management responder.
module ectp_mac_model
    import ectp_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Transmit client.
    input wire logic slow,
    output logic tx_ready,
    // Management access.
    input wire logic mgmt_req,
    input wire logic [4:0] mgmt_reg,
    input wire logic [15:0] spd_word,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cyc;
    logic [4:0] reg_r;
    int wait_r;
    int polls;
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc <= '0;
            wait_r <= 0;
            polls <= 0;
            tx_ready <= 1'b0;
            mgmt_done <= 1'b0;
        end
        else
        begin
            cyc <= cyc + 16'h0001;
            tx_ready <= !slow || cyc[0];
            mgmt_done <= 1'b0;
            mgmt_rdata <= ~cyc;
            if (mgmt_req)
                reg_r <= mgmt_reg;
            wait_r <= mgmt_req ? 3 : (wait_r > 0 ? wait_r - 1 : 0);
            if (wait_r == 1 && !mgmt_req)
            begin
                mgmt_done <= 1'b1;
                polls <= polls + int'(reg_r == ECTP_REG_PCS_STATUS);
                mgmt_rdata <= reg_r == ECTP_REG_PCS_STATUS ? {10'h000, polls > 0, 5'h00} : spd_word;
            end
        end
    end
endmodule : ectp_mac_model

// [ethernet_client_traffic_platform_bench.sv]
// Self-checking bench for the client traffic platform.
module ethernet_client_traffic_platform_bench
    import ectp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = '0, rst_n = '0, opt_type = '0, opt_length = '0, opt_vlan = '0, opt_corrupt = '0;
    logic opt_sweep = '0, phy_loop_cfg = '0, phy_absent = '0, autoneg_auto = '0, req_half = '0, slow = '0;
    logic rx_valid = '0, rx_last = '0, rx_err = '0, rx_addr_ok = '0, cpu_rd = '0;
    logic [1:0] tx_source = '0, req_speed = '0, mac_speed;
    logic [15:0] frame_size = 16'h0018, pause_len_cfg = '0, spd_word = '0, w0, w4, pause_val, mgmt_wdata, mgmt_rdata;
    logic [7:0] rx_data = '0, tx_data, cpu_rd_data;
    logic [5:0] cmds = '0;
    logic cmd_single, cmd_start, cmd_stop, cmd_pause, cmd_flush, cmd_restart_an, tx_valid, tx_last, tx_ready;
    logic pause_req, ed_ready, cpu_rd_valid, cpu_rd_last, cpu_frame_avail, mgmt_req, mgmt_wr, mgmt_done;
    logic mac_half, cfg_busy, gmii_loop;
    logic [4:0] mgmt_reg;
    logic [31:0] stat_frames, stat_bytes, seed = 32'h0000_a8f5, exp_frames = '0, exp_bytes = '0;
    logic [8:0] txq[$], rxq[$];
    int miscompares = 0, check_count = 0, cycles = 0, n;
    assign {cmd_single, cmd_start, cmd_stop, cmd_pause, cmd_flush, cmd_restart_an} = cmds;
    ectp_top #(.RXF_BYTES(64)) dut (.*, .ed_data(8'h00), .ed_valid(1'b0), .ed_last(1'b0));
    ectp_mac_model mac (.*);
    always #20 core_clk = ~core_clk;
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
        return seed;
    endfunction : rnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask : tick
    task automatic pulse(input int i);
        tick(1);
        cmds[i] = 1'b1;
        tick(1);
        cmds = '0;
    endtask : pulse
    task automatic drain();
        for (int i = 0; i < 3000 && txq.size() > 0; i++)
            tick(1);
        tick(8);
        check(txq.size(), 0);
    endtask : drain
    task automatic gen(input logic [3:0] o, input int len);
        logic [15:0] p, lt;
        logic [143:0] hv;
        int hl;
        hl = o[2] ? 18 : 14;
        p = 16'(len - hl);
        lt = o[3] ? p + ECTP_CORRUPT_DELTA : o[0] ? ECTP_TYPE_VAL : o[1] ? p : 16'h0000;
        hv = {ECTP_GEN_DA, ECTP_GEN_SA_DEF, o[2] ? {ECTP_VLAN_TPID, ECTP_VLAN_TCI_DEF, lt} : {lt, 32'h0000_0000}};
        for (int k = 0; k < len; k++)
            txq.push_back({k == len - 1, k < hl ? hv[143 - 8 * k -: 8] : 8'(k - hl + 2)});
    endtask : gen
    task automatic rx_frame(input int len, input logic ok, input logic e, input int mode);
        int j;
        for (int k = 0; k < len; k++)
        begin
            j = (mode == 3 && k < 12) ? (k + 6) % 12 : k;
            tick(1);
            {rx_valid, rx_last, rx_err, rx_addr_ok, rx_data} = {1'b1, k == len - 1, e, ok, 8'(len + k)};
            if (mode == 1)
                rxq.push_back({k == len - 1, 8'(len + k)});
            if (mode > 1)
                txq.push_back({k == len - 1, 8'(len + j)});
        end
        tick(1);
        rx_valid = 1'b0;
        exp_bytes += 32'(len);
        exp_frames += 32'(ok && !e);
    endtask : rx_frame
    task automatic cpu_read(input int k);
        repeat (k)
        begin
            tick(1);
            cpu_rd = 1'b1;
            tick(1);
            cpu_rd = 1'b0;
        end
        tick(4);
        check(rxq.size(), 0);
    endtask : cpu_read
    always @(posedge core_clk)
    begin
        cycles++;
        if (mgmt_req && mgmt_wr && mgmt_reg == ECTP_REG_PCS_CONTROL)
            w0 <= mgmt_wdata;
        if (mgmt_req && mgmt_wr && mgmt_reg == ECTP_REG_ADV)
            w4 <= mgmt_wdata;
        if (tx_valid && tx_ready)
            check({tx_last, tx_data}, txq.size() > 0 ? txq.pop_front() : 9'h1FF);
        if (cpu_rd_valid)
            check({cpu_rd_last, cpu_rd_data}, rxq.pop_front());
        if (cycles == 40000)
        begin
            miscompares++;
            $display("FAIL %0t: timeout", $time);
            results();
        end
    end
    initial
    begin
        tick(10);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            n = 23 + int'(rnd() % 16);
            slow = seed[3];
            {opt_corrupt, opt_vlan, opt_length, opt_type} = 4'h1 << i;
            frame_size = 16'(n);
            gen(4'h1 << i, n);
            pulse(5);
            drain();
        end
        $display("done: generator options");
        {opt_corrupt, opt_vlan, opt_length, opt_type, opt_sweep, slow, frame_size} = {6'h03, 16'h0015};
        for (int s = 19; s < 23; s++)
            gen(4'h0, s == 22 ? 19 : s);
        pulse(4);
        for (int i = 0; i < 3000 && txq.size() > 10; i++)
            tick(1);
        pulse(3);
        drain();
        opt_sweep = 1'b0;
        pause_len_cfg = 16'(rnd());
        pulse(2);
        check(pause_req, 1);
        check(pause_val, pause_len_cfg);
        tx_source = ECTP_SRC_EDIT;
        pulse(5);
        pulse(2);
        check(pause_req, 0);
        drain();
        $display("done: sweep and pause");
        tx_source = ECTP_SRC_GEN;
        pulse(1);
        rx_frame(40, 1, 0, 1);
        rx_frame(30, 1, 0, 0);
        rx_frame(16, 1, 0, 1);
        rx_frame(8, 1, 1, 0);
        cpu_read(56);
        rx_frame(12, 0, 0, 0);
        pulse(1);
        tick(1);
        check(cpu_frame_avail, 0);
        rx_frame(12, 1, 0, 1);
        cpu_read(12);
        check(stat_frames, exp_frames);
        check(stat_bytes, exp_bytes);
        for (int m = 2; m < 4; m++)
        begin
            tx_source = 2'(m);
            rx_frame(16 + m, 1, 0, m);
            cpu_read(1);
            drain();
        end
        $display("done: receive fifo and loopback");
        tx_source = ECTP_SRC_GEN;
        for (int r = 0; r < 2; r++)
        begin
            {autoneg_auto, req_speed, req_half, spd_word} = r ? {4'h5, 16'h0000} : {4'h8, 16'h6000};
            pulse(0);
            tick(2);
            for (int i = 0; i < 3000 && cfg_busy !== 1'b0; i++)
                tick(1);
            check(mac_speed, r ? ECTP_SPD_10M : ECTP_SPD_100M);
            check(mac_half, r);
            check({w0[12], w0[9], w4}, {2'b11, r ? ECTP_ADV_SEL | (16'h0001 << ECTP_ADV_10H_BIT) : ECTP_ADV_ALL});
        end
        phy_loop_cfg = 1'b1;
        for (int i = 0; i < 300 && w0[14] !== 1'b1; i++)
            tick(1);
        check(w0[14], 1);
        check(mac_speed, ECTP_SPD_1G);
        $display("done: link setup");
        results();
    end
endmodule : ethernet_client_traffic_platform_bench
